// ===== core/vivu_top.sv
// Top of the interrupt vector unit: register file, interrupter
// answer path and software interrupt line drive.
// Assumes VME cycle decode outside; acknowledge and strobes
// arrive as pulses synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module vivu_top (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       auto_id_powerup_option,
  // Interrupter side
  input  wire logic                       iack_in,
  input  wire logic [2:0]                 iack_in_level,
  output logic [7:0]                      vector_out,
  output logic                            vector_valid,
  output logic [7:1]                      vme_level_bit,
  // Handler side
  input  wire logic [2:1]                 vme_irq_in,
  output logic                            hiack_req,
  output logic [2:0]                      hiack_level,
  input  wire logic                       hiack_dtack,
  input  wire logic                       hiack_berr,
  input  wire logic [7:0]                 hiack_data,
  // AXI4-Lite
  input  wire logic                       s_awvalid,
  output logic                            s_awready,
  input  wire logic [vivu_pkg::ADDR_W-1:0] s_awaddr,
  input  wire logic                       s_wvalid,
  output logic                            s_wready,
  input  wire logic [31:0]                s_wdata,
  input  wire logic [3:0]                 s_wstrb,
  output logic                            s_bvalid,
  input  wire logic                       s_bready,
  output logic [1:0]                      s_bresp,
  input  wire logic                       s_arvalid,
  output logic                            s_arready,
  input  wire logic [vivu_pkg::ADDR_W-1:0] s_araddr,
  output logic                            s_rvalid,
  input  wire logic                       s_rready,
  output logic [31:0]                     s_rdata,
  output logic [1:0]                      s_rresp
);
  import vivu_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [6:0]      vid_r;
  logic            last_b0_r;
  logic            sw_pend_r;
  logic [2:0]      dest_r;
  logic [2:1]      en_r;
  logic [7:0]      vec_out_r;
  logic            vec_valid_r;
  logic [7:1]      irq_out_r;
  logic [2:1]      stat_w;
  logic [2:1][8:0] cap_w;
  logic            hreq_w;
  logic [2:0]      hlvl_w;

  // ****************************************
  // Bus front end
  // ****************************************
  logic                wr_go;
  logic [ADDR_W-1:0]   wr_addr;
  logic [31:0]         wr_data;
  logic [3:0]          wr_strb;
  logic [31:0]         rd_data;
  logic                rd_ok;
  logic                wr_ok;

  vivu_axil_slave u_slave (
    .clk       (clk),
    .rst       (rst),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_awaddr  (s_awaddr),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_bresp   (s_bresp),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rready  (s_rready),
    .s_rvalid  (s_rvalid),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok),
    .wr_ok     (wr_ok),
    .wr_go     (wr_go),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb)
  );

  // ****************************************
  // Write decode
  // ****************************************
  wire wr_vec   = wr_go & (wr_addr == OFS_VEC);
  wire wr_swp   = wr_go & (wr_addr == OFS_SWPEND);
  wire wr_dest  = wr_go & (wr_addr == OFS_DEST);
  wire wr_en    = wr_go & (wr_addr == OFS_EN);
  wire wr_stat  = wr_go & (wr_addr == OFS_STAT);
  // Captures are read-only; a write there is accepted and dropped
  wire wr_ro    = wr_go & ((wr_addr == OFS_CAP1) | (wr_addr == OFS_CAP2));
  assign wr_ok  = wr_vec | wr_swp | wr_dest | wr_en | wr_stat | wr_ro;
  wire [2:1] stat_clr = (wr_stat & wr_strb[0]) ? wr_data[2:1] : 2'h0;

  // ****************************************
  // Read decode
  // ****************************************
  wire rd_vec  = (s_araddr == OFS_VEC);
  wire rd_cap1 = (s_araddr == OFS_CAP1);
  wire rd_cap2 = (s_araddr == OFS_CAP2);
  wire rd_swp  = (s_araddr == OFS_SWPEND);
  wire rd_dest = (s_araddr == OFS_DEST);
  wire rd_en   = (s_araddr == OFS_EN);
  wire rd_stat = (s_araddr == OFS_STAT);
  assign rd_ok = rd_vec | rd_cap1 | rd_cap2 | rd_swp | rd_dest | rd_en | rd_stat;
  // Reserved bits read as zero
  wire [31:0] rv_vec  = {vid_r, last_b0_r, 24'h0};
  wire [31:0] rv_cap1 = {23'h0, cap_w[1]};
  wire [31:0] rv_cap2 = {23'h0, cap_w[2]};
  wire [31:0] rv_swp  = {31'h0, sw_pend_r};
  wire [31:0] rv_dest = {29'h0, dest_r};
  wire [31:0] rv_en   = {29'h0, en_r, 1'b0};
  wire [31:0] rv_stat = {29'h0, stat_w, 1'b0};
  assign rd_data = rd_vec  ? rv_vec  :
                   rd_cap1 ? rv_cap1 :
                   rd_cap2 ? rv_cap2 :
                   rd_swp  ? rv_swp  :
                   rd_dest ? rv_dest :
                   rd_en   ? rv_en   :
                   rd_stat ? rv_stat : 32'h0;

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      vid_r <= VID_RST;
    end else if (wr_vec & wr_strb[3]) begin
      vid_r <= wr_data[31:25];
    end
  end

  // Strap sampled by the clocked reset, never asynchronously
  always_ff @(posedge clk) begin
    if (rst) begin
      dest_r <= auto_id_powerup_option ? DEST_AUTO : DEST_RST;
    end else if (wr_dest & wr_strb[0]) begin
      dest_r <= wr_data[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      en_r <= 2'h0;
    end else if (wr_en & wr_strb[0]) begin
      en_r <= wr_data[2:1];
    end
  end

  // ****************************************
  // Interrupter answer
  // ****************************************
  wire dest_live = (dest_r != 3'h0);
  wire sw_match  = sw_pend_r & dest_live & (dest_r == iack_in_level);
  wire b0_nxt    = ~sw_match;

  // Own acknowledge retires the pending request; software set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_pend_r <= 1'b0;
    end else if (wr_swp & wr_strb[0]) begin
      sw_pend_r <= wr_data[0];
    end else if (iack_in & sw_match) begin
      sw_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vec_out_r   <= 8'hFF;
      vec_valid_r <= 1'b0;
      last_b0_r   <= 1'b1;
    end else begin
      vec_valid_r <= iack_in;
      if (iack_in) begin
        vec_out_r <= {vid_r, b0_nxt};
        last_b0_r <= b0_nxt;
      end
    end
  end

  // ****************************************
  // Software interrupt line drive
  // ****************************************
  genvar g;
  for (g = 1; g <= 7; g++) begin : g_line
    always_ff @(posedge clk) begin
      if (rst) begin
        irq_out_r[g] <= 1'b0;
      end else begin
        irq_out_r[g] <= sw_pend_r & (dest_r == 3'(g));
      end
    end
  end

  // ****************************************
  // Handler
  // ****************************************
  vivu_iack_handler u_hnd (
    .clk      (clk),
    .rst      (rst),
    .lvl_en   (en_r),
    .irq_in   (vme_irq_in),
    .stat_clr (stat_clr),
    .dtack    (hiack_dtack),
    .berr     (hiack_berr),
    .data_in  (hiack_data),
    .req_r    (hreq_w),
    .level_r  (hlvl_w),
    .stat_r   (stat_w),
    .cap_r    (cap_w)
  );

  assign vector_out    = vec_out_r;
  assign vector_valid  = vec_valid_r;
  assign vme_level_bit = irq_out_r;
  assign hiack_req     = hreq_w;
  assign hiack_level   = hlvl_w;

  // ****************************************
  // Checks
  // ****************************************
  property p_vec_byte;
    @(posedge clk) disable iff (rst)
      (iack_in && !(wr_vec && wr_strb[3])) |=> vector_valid && vector_out[7:1] == $past(vid_r);
  endproperty
  a_vec_byte: assert property (p_vec_byte) else $error("Vector byte not returned");

  property p_b0_low;
    @(posedge clk) disable iff (rst)
      (iack_in && sw_pend_r && dest_r != 3'h0 && dest_r == iack_in_level) |=> !vector_out[0];
  endproperty
  a_b0_low: assert property (p_b0_low) else $error("Bit 0 high on own level");

  property p_b0_high;
    @(posedge clk) disable iff (rst)
      (iack_in && (!sw_pend_r || dest_r != iack_in_level)) |=> vector_out[0];
  endproperty
  a_b0_high: assert property (p_b0_high) else $error("Bit 0 low on foreign level");

  property p_vid_reset;
    @(posedge clk) disable iff (rst)
      $past(rst) |-> vid_r == VID_RST && dest_r == ($past(auto_id_powerup_option) ? DEST_AUTO : DEST_RST);
  endproperty
  a_vid_reset: assert property (p_vid_reset) else $error("Reset values wrong");

  property p_vec_read;
    @(posedge clk) disable iff (rst)
      (s_arvalid && s_arready && s_araddr == OFS_VEC) |=>
        s_rvalid && s_rdata[31:25] == $past(vid_r) && s_rdata[23:0] == 24'h0;
  endproperty
  a_vec_read: assert property (p_vec_read) else $error("Vector register read wrong");

  property p_cap_read;
    @(posedge clk) disable iff (rst)
      (s_arvalid && s_arready && s_araddr == OFS_CAP1) |=> s_rdata == {23'h0, $past(cap_w[1])};
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("Level 1 capture read wrong");

  property p_mask;
    @(posedge clk) disable iff (rst)
      (dest_r == 3'h0) |=> vme_level_bit == 7'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("Masked destination drives a line");

  property p_line;
    @(posedge clk) disable iff (rst)
      (sw_pend_r && dest_r == 3'h2) ##1 (dest_r == 3'h2) |-> vme_level_bit[2];
  endproperty
  a_line: assert property (p_line) else $error("Line 2 not driven");

  property p_vld_pulse;
    @(posedge clk) disable iff (rst)
      !iack_in |=> !vector_valid;
  endproperty
  a_vld_pulse: assert property (p_vld_pulse) else $error("Vector valid without acknowledge");

  property p_vec_hold;
    @(posedge clk) disable iff (rst)
      !iack_in |=> $stable(vector_out);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("Vector byte moved without acknowledge");

  property p_vid_write;
    @(posedge clk) disable iff (rst)
      (wr_vec && wr_strb[3]) |=> vid_r == $past(wr_data[31:25]);
  endproperty
  a_vid_write: assert property (p_vid_write) else $error("Vector bits not written");

  property p_swp_retire;
    @(posedge clk) disable iff (rst)
      (iack_in && sw_match && !(wr_swp && wr_strb[0])) |=> !sw_pend_r;
  endproperty
  a_swp_retire: assert property (p_swp_retire) else $error("Pending not retired by own acknowledge");

  property p_line1;
    @(posedge clk) disable iff (rst)
      (sw_pend_r && dest_r == 3'h1) |=> vme_level_bit == 7'h01;
  endproperty
  a_line1: assert property (p_line1) else $error("Line 1 not driven alone");

  property p_line_off;
    @(posedge clk) disable iff (rst)
      !sw_pend_r |=> vme_level_bit == 7'h00;
  endproperty
  a_line_off: assert property (p_line_off) else $error("Line driven with nothing pending");

  property p_cap1_end;
    @(posedge clk) disable iff (rst)
      (hiack_req && hiack_level == 3'h1 && (hiack_dtack || hiack_berr)) |=>
        stat_w[1] && cap_w[1] == {$past(hiack_berr), $past(hiack_data)};
  endproperty
  a_cap1_end: assert property (p_cap1_end) else $error("Level 1 capture wrong");

  property p_cap2_read;
    @(posedge clk) disable iff (rst)
      (s_arvalid && s_arready && s_araddr == OFS_CAP2) |=> s_rdata == {23'h0, $past(cap_w[2])};
  endproperty
  a_cap2_read: assert property (p_cap2_read) else $error("Level 2 capture read wrong");

  property p_ro_write;
    @(posedge clk) disable iff (rst)
      (wr_ro && !(hiack_req && (hiack_dtack || hiack_berr))) |=> $stable(cap_w);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("Capture changed by a write");

  property p_stat_clear;
    @(posedge clk) disable iff (rst)
      (stat_clr[1] && !(hiack_req && hiack_level == 3'h1 && (hiack_dtack || hiack_berr))) |=> !stat_w[1];
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("Level 1 status not cleared");

  property p_en_gate;
    @(posedge clk) disable iff (rst)
      (en_r == 2'h0) |=> !$rose(hiack_req);
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("Acknowledge started with no level enabled");
endmodule
`default_nettype wire

// ===== core/vivu_pkg.sv
// Constants shared by the interrupt vector unit files.
// Assumes a 12-bit AXI4-Lite byte address and 32-bit data.
package vivu_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] OFS_VEC     = 12'h320;
  localparam logic [11:0] OFS_CAP1    = 12'h324;
  localparam logic [11:0] OFS_CAP2    = 12'h328;
  localparam logic [11:0] OFS_SWPEND  = 12'h340;
  localparam logic [11:0] OFS_DEST    = 12'h344;
  localparam logic [11:0] OFS_EN      = 12'h348;
  localparam logic [11:0] OFS_STAT    = 12'h34C;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int          VEC_POS     = 24;
  localparam int          ERR_POS     = 8;
  localparam logic [6:0]  VID_RST     = 7'h7F;
  localparam logic [8:0]  CAP_RST     = 9'h000;
  localparam logic [2:0]  DEST_AUTO   = 3'h2;
  localparam logic [2:0]  DEST_RST    = 3'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic {H_IDLE, H_BUSY} vivu_hstate_type;
endpackage

// ===== core/vivu_axil_slave.sv
// AXI4-Lite slave front end for the vector unit registers.
// Assumes the parent decodes addresses and supplies read data.
`timescale 1ns/1ps
`default_nettype none
module vivu_axil_slave (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       s_awvalid,
  output logic                            s_awready,
  input  wire logic [vivu_pkg::ADDR_W-1:0] s_awaddr,
  input  wire logic                       s_wvalid,
  output logic                            s_wready,
  input  wire logic [31:0]                s_wdata,
  input  wire logic [3:0]                 s_wstrb,
  output logic                            s_bvalid,
  input  wire logic                       s_bready,
  output logic [1:0]                      s_bresp,
  input  wire logic                       s_arvalid,
  output logic                            s_arready,
  input  wire logic                       s_rready,
  output logic                            s_rvalid,
  output logic [31:0]                     s_rdata,
  output logic [1:0]                      s_rresp,
  input  wire logic [31:0]                rd_data,
  input  wire logic                       rd_ok,
  input  wire logic                       wr_ok,
  output logic                            wr_go,
  output logic [vivu_pkg::ADDR_W-1:0]     wr_addr,
  output logic [31:0]                     wr_data,
  output logic [3:0]                      wr_strb
);
  import vivu_pkg::*;
  logic awready_r, wready_r, arready_r, bvalid_r, rvalid_r;
  logic aw_hold_r, w_hold_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  wire aw_fire = s_awvalid & awready_r;
  wire w_fire  = s_wvalid & wready_r;
  wire ar_fire = s_arvalid & arready_r;
  // Address and data may arrive in either order
  assign wr_go = aw_hold_r & w_hold_r;
  wire aw_nxt = (aw_hold_r | aw_fire) & ~wr_go;
  wire w_nxt  = (w_hold_r | w_fire) & ~wr_go;
  wire bvalid_nxt = wr_go | (bvalid_r & ~s_bready);
  wire rvalid_nxt = ar_fire | (rvalid_r & ~s_rready);
  always_ff @(posedge clk) begin
    if (rst) begin
      {aw_hold_r, w_hold_r, bvalid_r, rvalid_r} <= 4'h0;
      {awready_r, wready_r, arready_r} <= 3'h7;
      bresp_r <= RESP_OKAY;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0;
      wr_addr <= '0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
    end else begin
      aw_hold_r <= aw_nxt;
      w_hold_r  <= w_nxt;
      bvalid_r  <= bvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      awready_r <= ~aw_nxt & ~bvalid_nxt;
      wready_r  <= ~w_nxt & ~bvalid_nxt;
      arready_r <= ~rvalid_nxt;
      if (aw_fire) wr_addr <= s_awaddr;
      if (w_fire) begin
        wr_data <= s_wdata;
        wr_strb <= s_wstrb;
      end
      if (wr_go) bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (ar_fire) begin
        rdata_r <= rd_data;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
  assign s_awready = awready_r;
  assign s_wready  = wready_r;
  assign s_arready = arready_r;
  assign s_bvalid  = bvalid_r;
  assign s_bresp   = bresp_r;
  assign s_rvalid  = rvalid_r;
  assign s_rdata   = rdata_r;
  assign s_rresp   = rresp_r;
endmodule
`default_nettype wire

// ===== core/vivu_iack_handler.sv
// Handler side: runs acknowledge cycles for levels 1 and 2
// and keeps the captured vector and error flag per level.
// Assumes the bus side ends each cycle with dtack or berr.
`timescale 1ns/1ps
`default_nettype none
module vivu_iack_handler (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [2:1]       lvl_en,
  input  wire logic [2:1]       irq_in,
  input  wire logic [2:1]       stat_clr,
  input  wire logic             dtack,
  input  wire logic             berr,
  input  wire logic [7:0]       data_in,
  output logic                  req_r,
  output logic [2:0]            level_r,
  output logic [2:1]            stat_r,
  output logic [2:1][8:0]       cap_r
);
  import vivu_pkg::*;
  vivu_hstate_type state_r;
  wire          ends = (state_r == H_BUSY) & (dtack | berr);
  // Level 2 wins; a set status bit blocks its level
  wire [2:1]    want = lvl_en & irq_in & ~stat_r;
  logic [2:1]   done;
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= H_IDLE;
      req_r   <= 1'b0;
      level_r <= 3'h0;
    end else begin
      case (state_r)
        H_IDLE: if (|want) begin
          state_r <= H_BUSY;
          req_r   <= 1'b1;
          level_r <= want[2] ? 3'h2 : 3'h1;
        end
        H_BUSY: if (ends) begin
          state_r <= H_IDLE;
          req_r   <= 1'b0;
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end
  genvar l;
  for (l = 1; l <= 2; l++) begin : g_lvl
    assign done[l] = ends & (level_r == 3'(l));
    always_ff @(posedge clk) begin
      if (rst) begin
        cap_r[l]  <= CAP_RST;
        stat_r[l] <= 1'b0;
      end else begin
        if (done[l]) cap_r[l] <= {berr, data_in};
        // Completion beats a clear in the same cycle
        stat_r[l] <= done[l] | (stat_r[l] & ~stat_clr[l]);
      end
    end
  end
  property p_hnd_blocked;
    @(posedge clk) disable iff (rst)
      (stat_r[1] & ~stat_clr[1]) |=> !(req_r && level_r == 3'h1 && $rose(req_r));
  endproperty
  a_hnd_blocked: assert property (p_hnd_blocked) else $error("Level 1 acknowledged while status set");
  property p_hnd_enable;
    @(posedge clk) disable iff (rst)
      $rose(req_r) |-> (level_r == 3'h1 && $past(lvl_en[1])) || (level_r == 3'h2 && $past(lvl_en[2]));
  endproperty
  a_hnd_enable: assert property (p_hnd_enable) else $error("Acknowledge at a disabled level");
  property p_hnd_capture;
    @(posedge clk) disable iff (rst)
      (ends && level_r == 3'h2) |=> cap_r[2] == {$past(berr), $past(data_in)} && stat_r[2];
  endproperty
  a_hnd_capture: assert property (p_hnd_capture) else $error("Level 2 capture wrong");
endmodule
`default_nettype wire

// ===== tb/vivu_vme_peer.sv
// Far side of the handler path: a bus interrupter answering acknowledge cycles.
// Assumes hiack_req stays high until the edge after the answer pulse.
`timescale 1ns/1ps
`default_nettype none
module vivu_vme_peer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       hiack_req,
  input  wire logic [2:0] hiack_level,
  input  wire logic [3:0] delay,
  input  wire logic       use_berr,
  output logic            dtack,
  output logic            berr,
  output logic [7:0]      data
);
  logic [3:0] cnt_r;
  logic       done_r;
  // ****************************************
  // Answer path
  // ****************************************
  always_ff @(posedge clk) begin
    dtack <= 1'b0;
    berr  <= 1'b0;
    if (rst) begin
      cnt_r  <= 4'h0;
      done_r <= 1'b0;
      data   <= 8'h5A;
    end else if (!hiack_req || done_r) begin
      // Released bus: keep it moving so no stale vector looks valid
      cnt_r  <= 4'h0;
      done_r <= hiack_req;
      data   <= ~data;
    end else if (cnt_r == delay) begin
      done_r <= 1'b1;
      dtack  <= !use_berr;
      berr   <= use_berr;
      data   <= {5'h15, hiack_level};
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the interrupt vector unit top.
// Assumes the peer model answers handler cycles; bench is AXI master.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vivu_pkg::*;
  logic        clk = 0, rst = 1, strap = 0, iack_in = 0;
  logic [2:0]  iack_lvl = 0, hlvl;
  logic [7:0]  vec, hdata;
  logic [7:1]  lvlbit;
  logic [2:1]  irq = 0;
  logic        vvalid, hreq, dtk, berr, pberr = 0;
  logic [3:0]  pdly = 0, ws = 0;
  logic        awv = 0, awr, wv = 0, wr_rdy, bv, br = 0, arv = 0, arr, rv, rr = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0]  bresp, rresp;
  int          errors = 0, tests_run = 0;

  always #5 clk = ~clk;

  vivu_top dut (.clk(clk), .rst(rst), .auto_id_powerup_option(strap), .iack_in(iack_in),
    .iack_in_level(iack_lvl), .vector_out(vec), .vector_valid(vvalid), .vme_level_bit(lvlbit),
    .vme_irq_in(irq), .hiack_req(hreq), .hiack_level(hlvl), .hiack_dtack(dtk),
    .hiack_berr(berr), .hiack_data(hdata), .s_awvalid(awv), .s_awready(awr), .s_awaddr(awa),
    .s_wvalid(wv), .s_wready(wr_rdy), .s_wdata(wd), .s_wstrb(ws), .s_bvalid(bv),
    .s_bready(br), .s_bresp(bresp), .s_arvalid(arv), .s_arready(arr), .s_araddr(ara),
    .s_rvalid(rv), .s_rready(rr), .s_rdata(rd), .s_rresp(rresp));

  vivu_vme_peer peer (.clk(clk), .rst(rst), .hiack_req(hreq), .hiack_level(hlvl),
    .delay(pdly), .use_berr(pberr), .dtack(dtk), .berr(berr), .data(hdata));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic tmo;
    errors++;
    $display("FAIL t=%0t got=%h exp=%h", $time, 0, 1);
    tally_and_finish();
  endtask

  // ****************************************
  // Bus and event drivers
  // ****************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    @(posedge clk);
    awv <= 1; awa <= a; wv <= 1; wd <= d; ws <= s; br <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr_rdy) wv <= 0;
      if (bv) break;
    end
    if (n == 40) tmo();
    br <= 0;
    chk(bresp, er);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    arv <= 1; ara <= a; rr <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv) break;
    end
    if (n == 40) tmo();
    rr <= 0;
    if (er == RESP_OKAY) chk(rd, e);
    chk(rresp, er);
  endtask

  task automatic ack(input logic [2:0] l, input logic [7:0] e);
    @(posedge clk);
    iack_in <= 1; iack_lvl <= l;
    @(posedge clk);
    iack_in <= 0;
    #1;
    chk(vvalid, 1);
    chk(vec, e);
  endtask

  task automatic wreq(input logic v);
    int n;
    for (n = 0; n < 30 && hreq !== v; n++) @(posedge clk);
    if (n == 30) tmo();
  endtask

  task automatic noreq(input int c);
    int k = 0;
    repeat (c) begin
      @(posedge clk);
      if (hreq !== 1'b0) k++;
    end
    chk(k, 0);
  endtask

  task automatic reset(input logic s);
    @(posedge clk);
    rst <= 1; strap <= s;
    repeat (10) @(posedge clk);
    rst <= 0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rdc(OFS_VEC, 32'hFF000000, RESP_OKAY);
    rdc(OFS_CAP1, 32'h0, RESP_OKAY);
    rdc(OFS_CAP2, 32'h0, RESP_OKAY);
    rdc(OFS_DEST, 32'h0, RESP_OKAY);
    rdc(12'h100, 32'h0, RESP_SLVERR);
    wr(12'h100, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
    chk(vec, 8'hFF);
    chk(lvlbit, 7'h00);
    $display("test reset done");
  endtask

  task automatic t_vec;
    wr(OFS_VEC, 32'hA4000000, 4'h8, RESP_OKAY);
    wr(OFS_VEC, 32'h12FFFFFF, 4'h7, RESP_OKAY);
    rdc(OFS_VEC, 32'hA5000000, RESP_OKAY);
    ack(3'h3, 8'hA5);
    wr(OFS_DEST, 32'h3, 4'h1, RESP_OKAY);
    wr(OFS_SWPEND, 32'h1, 4'h1, RESP_OKAY);
    rdc(OFS_SWPEND, 32'h1, RESP_OKAY);
    chk(lvlbit, 7'h04);
    ack(3'h2, 8'hA5);
    ack(3'h3, 8'hA4);
    ack(3'h3, 8'hA5);
    rdc(OFS_SWPEND, 32'h0, RESP_OKAY);
    chk(lvlbit, 7'h00);
    wr(OFS_DEST, 32'h0, 4'h1, RESP_OKAY);
    wr(OFS_SWPEND, 32'h1, 4'h1, RESP_OKAY);
    rdc(OFS_DEST, 32'h0, RESP_OKAY);
    chk(lvlbit, 7'h00);
    ack(3'h1, 8'hA5);
    wr(OFS_DEST, 32'h1, 4'h1, RESP_OKAY);
    rdc(OFS_DEST, 32'h1, RESP_OKAY);
    chk(lvlbit, 7'h01);
    ack(3'h1, 8'hA4);
    rdc(OFS_VEC, 32'hA4000000, RESP_OKAY);
    $display("test interrupter done");
  endtask

  task automatic t_hnd;
    pdly <= 3; pberr <= 0;
    wr(OFS_EN, 32'h6, 4'h1, RESP_OKAY);
    irq <= 2'b01;
    wreq(1);
    chk(hlvl, 3'h1);
    wreq(0);
    rdc(OFS_CAP1, 32'h000000A9, RESP_OKAY);
    rdc(OFS_STAT, 32'h2, RESP_OKAY);
    noreq(20);
    wr(OFS_STAT, 32'h2, 4'h1, RESP_OKAY);
    wreq(1);
    wreq(0);
    irq <= 2'b00;
    rdc(OFS_STAT, 32'h2, RESP_OKAY);
    pberr <= 1; pdly <= 0; irq <= 2'b10;
    wreq(1);
    chk(hlvl, 3'h2);
    wreq(0);
    irq <= 2'b00;
    rdc(OFS_CAP2, 32'h000001AA, RESP_OKAY);
    wr(OFS_CAP1, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    rdc(OFS_CAP1, 32'h000000A9, RESP_OKAY);
    wr(OFS_EN, 32'h0, 4'h1, RESP_OKAY);
    wr(OFS_STAT, 32'h6, 4'h1, RESP_OKAY);
    irq <= 2'b11;
    noreq(20);
    irq <= 2'b00;
    $display("test handler done");
  endtask

  task automatic t_auto;
    reset(1);
    wr(OFS_SWPEND, 32'h1, 4'h1, RESP_OKAY);
    rdc(OFS_DEST, 32'h2, RESP_OKAY);
    chk(lvlbit, 7'h02);
    ack(3'h2, 8'hFE);
    reset(0);
    rdc(OFS_DEST, 32'h0, RESP_OKAY);
    rdc(OFS_CAP2, 32'h0, RESP_OKAY);
    rdc(OFS_VEC, 32'hFF000000, RESP_OKAY);
    $display("test strap done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_reset();
    t_vec();
    t_hnd();
    t_auto();
    tally_and_finish();
  end
endmodule
`default_nettype wire
